// file: hdl/adc_cfg.svh
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define ADC_OFS_BUS_CTRL 12'h000
`define ADC_OFS_DRAM_CTRL 12'h004
`define ADC_OFS_LWAIT_CTRL 12'h008
`define ADC_OFS_STATUS 12'h00C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ADC_BCR_DRAM_BIT 0
`define ADC_BCR_IO_BIT 1
`define ADC_DCR_MUX_BIT 0
`define ADC_LW_A02_LO 0
`define ADC_LW_A6_LO 2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ADC_RST_BCR 2'h0
`define ADC_RST_DCR 1'h0
`define ADC_RST_LWAIT 4'hF

// ------------------------------------------------------------
// decode constants
// ------------------------------------------------------------
`define ADC_MODE_EXT8 3'h0
`define ADC_MODE_EXT16 3'h1
`define ADC_MODE_ROM32 3'h2
`define ADC_AREA_LSB 24
`define ADC_WIDTH_BIT 27
`define ADC_ROM16K_BITS 14
`define ADC_ROM32K_BITS 15
`define ADC_PERIPH_BITS 9
`define ADC_RAM_BITS 10
`define ADC_EXT_BITS 22
`define ADC_PERIPH_WBIT 8
`define ADC_MUXIO_WBIT 14

`endif

// file: hdl/adc_pkg.sv
package adc_pkg;

    typedef enum logic [2:0] {
        ADC_TGT_NONE,
        ADC_TGT_ROM,
        ADC_TGT_RAM,
        ADC_TGT_PERIPH,
        ADC_TGT_EXT,
        ADC_TGT_DRAM,
        ADC_TGT_MUXIO
    } adc_target_t;

    typedef enum logic [1:0] {
        ADC_W8,
        ADC_W16,
        ADC_W32
    } adc_width_t;

    typedef enum logic [1:0] {
        ADC_ST_IDLE,
        ADC_ST_RESP
    } adc_bus_st_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } adc_req_t;

    typedef struct packed {
        logic [7:0] sel_n;
        adc_target_t target;
        adc_width_t width;
        logic [23:0] ext_addr;
        logic ext_a23_a22_drive;
        logic row_col_mux;
        logic [2:0] long_wait;
    } adc_dec_t;

    typedef struct packed {
        adc_bus_st_t st;
        logic hwrite;
        logic [11:0] haddr;
        logic [31:0] hrdata;
        logic [1:0] bus_control_reg;
        logic dram_control_reg;
        logic [3:0] lwait;
        adc_dec_t dec;
    } adc_state_t;

endpackage

// file: hdl/adc_area_decode.sv
`timescale 1ns/100ps
`include "adc_cfg.svh"
// Operation
// - address bits 26-24 pick area 0-7; its low-active select goes low during external or muxed I/O access
// - selects assert only for external and area 6 muxed I/O accesses; areas 0,5,7 on-chip stay high
// - area 1 DRAM accesses keep area 1 select high
// - bits 23,22 not driven except row/column muxing; 4 Mbyte shadows
// - bit 27 only changes valid data lanes in switchable areas
// - area 0 set by boot mode pins: 000 ext8, 001 ext16, 010 rom32
// - rom ignores bits 23-14 (16k) or 23-15 (32k)
// - areas 0 and 2 external use shared two-bit long wait, 1 to 4
// - area 1 is DRAM space when DRAM enable set, else external
// - areas 1-4 external: 8-bit at bit27=0, 16-bit at bit27=1
// - row/column mux drives bits 23-0, 16 Mbyte DRAM space
// - areas 2,3,4 always external, selects asserted
// - area 5 bit27=0 peripherals, 512 byte shadows, bit 8 width, select high
// - area 5 bit27=1 external 16-bit, select asserted
// - area 6 bit27=0 muxed I/O if enabled else external; bit27=1 external
// - muxed I/O: bit 14 selects width, area 6 select asserted
// - area 6 external: bit 14 width at bit27=0, 16-bit at bit27=1
// - area 6 external uses own two-bit long wait field
// - area 7 bit27=0 external 8-bit, select asserted, bits 23,22 hidden
// - area 7 bit27=1 on-chip 1 kbyte 32-bit RAM, ignore 23-10, select high
// - top four address bits ignored, only 28-bit address decoded
module adc_area_decode import adc_pkg::*; #(
    parameter bit ROM_32K = 1'b0
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire adc_req_t req_in,
    input wire logic [2:0] boot_mode_pins_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [7:0] area_select_n_out,
    output adc_target_t target_out,
    output adc_width_t width_out,
    output logic [23:0] ext_addr_out,
    output logic ext_a23_a22_drive_out,
    output logic row_col_mux_out,
    output logic [2:0] long_wait_out
);

    // ------------------------------------------------------------
    // mode pins, two-flop synchroniser
    // ------------------------------------------------------------
    logic [2:0] mode_meta_ff;
    logic [2:0] mode_sync_ff;

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            mode_meta_ff <= 3'h0;
            mode_sync_ff <= 3'h0;
        end else begin
            mode_meta_ff <= boot_mode_pins_in;
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adc_state_t cur_ff;
    adc_state_t nxt_cur;

    // ------------------------------------------------------------
    // decode function
    // ------------------------------------------------------------
    function automatic adc_dec_t decode(input adc_req_t r, input logic [2:0] mode, input logic dram_en,
                                        input logic io_en, input logic mux_en, input logic [3:0] lw);
        adc_dec_t d;
        logic [2:0] area;
        logic hi;
        logic ext;
        d = '0;
        d.sel_n = 8'hFF;
        d.target = ADC_TGT_NONE;
        d.width = ADC_W8;
        area = r.addr[`ADC_AREA_LSB +: 3];
        hi = r.addr[`ADC_WIDTH_BIT];
        ext = 1'b0;
        if (r.valid) begin
            d.width = hi ? ADC_W16 : ADC_W8;
            case (area)
                3'h0: begin
                    if (mode == `ADC_MODE_ROM32) begin
                        d.target = ADC_TGT_ROM;
                        d.width = ADC_W32;
                    end else begin
                        ext = 1'b1;
                        d.width = (mode == `ADC_MODE_EXT16) ? ADC_W16 : ADC_W8;
                        d.long_wait = {1'b0, lw[`ADC_LW_A02_LO +: 2]} + 3'h1;
                    end
                end
                3'h1: begin
                    if (dram_en) begin
                        d.target = ADC_TGT_DRAM;
                        d.row_col_mux = mux_en;
                    end else begin
                        ext = 1'b1;
                    end
                end
                3'h2: begin
                    ext = 1'b1;
                    d.long_wait = {1'b0, lw[`ADC_LW_A02_LO +: 2]} + 3'h1;
                end
                3'h3, 3'h4: begin
                    ext = 1'b1;
                end
                3'h5: begin
                    if (hi) begin
                        ext = 1'b1;
                        d.width = ADC_W16;
                    end else begin
                        d.target = ADC_TGT_PERIPH;
                        d.width = r.addr[`ADC_PERIPH_WBIT] ? ADC_W16 : ADC_W8;
                    end
                end
                3'h6: begin
                    if (!hi && io_en) begin
                        d.target = ADC_TGT_MUXIO;
                        d.sel_n[6] = 1'b0;
                        d.width = r.addr[`ADC_MUXIO_WBIT] ? ADC_W16 : ADC_W8;
                    end else begin
                        ext = 1'b1;
                        d.width = (hi || r.addr[`ADC_MUXIO_WBIT]) ? ADC_W16 : ADC_W8;
                        d.long_wait = {1'b0, lw[`ADC_LW_A6_LO +: 2]} + 3'h1;
                    end
                end
                default: begin
                    if (hi) begin
                        d.target = ADC_TGT_RAM;
                        d.width = ADC_W32;
                    end else begin
                        ext = 1'b1;
                        d.width = ADC_W8;
                    end
                end
            endcase
            if (ext) begin
                d.target = ADC_TGT_EXT;
                d.sel_n[area] = 1'b0;
            end
            // address seen by the target, with shadows folded away
            case (d.target)
                ADC_TGT_ROM: d.ext_addr = ROM_32K ? {9'h0, r.addr[`ADC_ROM32K_BITS-1:0]}
                                                  : {10'h0, r.addr[`ADC_ROM16K_BITS-1:0]};
                ADC_TGT_PERIPH: d.ext_addr = {15'h0, r.addr[`ADC_PERIPH_BITS-1:0]};
                ADC_TGT_RAM: d.ext_addr = {14'h0, r.addr[`ADC_RAM_BITS-1:0]};
                ADC_TGT_DRAM: d.ext_addr = mux_en ? r.addr[23:0]
                                                  : {2'h0, r.addr[`ADC_EXT_BITS-1:0]};
                default: d.ext_addr = {2'h0, r.addr[`ADC_EXT_BITS-1:0]};
            endcase
            d.ext_a23_a22_drive = (d.target == ADC_TGT_DRAM) && mux_en;
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // next state: bus slave plus registered decode
    // ------------------------------------------------------------
    always_comb begin
        nxt_cur = cur_ff;
        // unmapped offsets read zero and ignore writes
        if (cur_ff.st == ADC_ST_RESP && cur_ff.hwrite) begin
            if (cur_ff.haddr == `ADC_OFS_BUS_CTRL) begin
                nxt_cur.bus_control_reg = hwdata_in[1:0];
            end else if (cur_ff.haddr == `ADC_OFS_DRAM_CTRL) begin
                nxt_cur.dram_control_reg = hwdata_in[`ADC_DCR_MUX_BIT];
            end else if (cur_ff.haddr == `ADC_OFS_LWAIT_CTRL) begin
                nxt_cur.lwait = hwdata_in[3:0];
            end
        end
        nxt_cur.st = ADC_ST_IDLE;
        if (hsel_in && hready_in && htrans_in[1]) begin
            nxt_cur.st = ADC_ST_RESP;
            nxt_cur.hwrite = hwrite_in;
            nxt_cur.haddr = haddr_in[11:0];
            nxt_cur.hrdata = 32'h0;
            if (haddr_in[11:0] == `ADC_OFS_BUS_CTRL) begin
                nxt_cur.hrdata = {30'h0, cur_ff.bus_control_reg};
            end else if (haddr_in[11:0] == `ADC_OFS_DRAM_CTRL) begin
                nxt_cur.hrdata = {31'h0, cur_ff.dram_control_reg};
            end else if (haddr_in[11:0] == `ADC_OFS_LWAIT_CTRL) begin
                nxt_cur.hrdata = {28'h0, cur_ff.lwait};
            end else if (haddr_in[11:0] == `ADC_OFS_STATUS) begin
                nxt_cur.hrdata = {cur_ff.dec.sel_n, 1'b0, cur_ff.dec.target, 2'h0, cur_ff.dec.width,
                                  mode_sync_ff, 1'b0, cur_ff.dec.long_wait, cur_ff.dec.row_col_mux,
                                  cur_ff.dec.ext_a23_a22_drive, 7'h0};
            end
        end
        nxt_cur.dec = decode(req_in, mode_sync_ff, cur_ff.bus_control_reg[`ADC_BCR_DRAM_BIT],
                             cur_ff.bus_control_reg[`ADC_BCR_IO_BIT], cur_ff.dram_control_reg, cur_ff.lwait);
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            cur_ff <= '0;
            cur_ff.bus_control_reg <= `ADC_RST_BCR;
            cur_ff.dram_control_reg <= `ADC_RST_DCR;
            cur_ff.lwait <= `ADC_RST_LWAIT;
            cur_ff.dec.sel_n <= 8'hFF;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // hsize_in is accepted but only whole-word transfers are expected
    assign hrdata_out = cur_ff.hrdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign area_select_n_out = cur_ff.dec.sel_n;
    assign target_out = cur_ff.dec.target;
    assign width_out = cur_ff.dec.width;
    assign ext_addr_out = cur_ff.dec.ext_addr;
    assign ext_a23_a22_drive_out = cur_ff.dec.ext_a23_a22_drive;
    assign row_col_mux_out = cur_ff.dec.row_col_mux;
    assign long_wait_out = cur_ff.dec.long_wait;

endmodule

// file: testbench/adc_area_decode_assertions.sv
`timescale 1ns/100ps
module adc_area_decode_chk import adc_pkg::*; (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire adc_req_t req_in,
    input wire logic [2:0] boot_mode_pins_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [7:0] area_select_n_out,
    input wire adc_target_t target_out,
    input wire adc_width_t width_out,
    input wire logic [23:0] ext_addr_out,
    input wire logic ext_a23_a22_drive_out,
    input wire logic row_col_mux_out,
    input wire logic [2:0] long_wait_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    logic v;
    logic a27;
    logic [2:0] ar;
    assign v = req_in.valid;
    assign a27 = req_in.addr[27];
    assign ar = req_in.addr[26:24];
    property p_idle; !v |=> area_select_n_out == 8'hFF && target_out == ADC_TGT_NONE; endproperty
    a_idle: assert property (p_idle) else $error("selects not idle");
    property p_sel; v && ar inside {[2:4]} |=> area_select_n_out == ~(8'h01 << $past(ar)); endproperty
    a_sel: assert property (p_sel) else $error("wrong area select");
    property p_w24; v && ar inside {[2:4]} |=> target_out == ADC_TGT_EXT && width_out == ($past(a27) ? ADC_W16 : ADC_W8);
    endproperty
    a_w24: assert property (p_w24) else $error("area 2-4 decode wrong");
    property p_per; v && ar == 3'h5 && !a27 |=> area_select_n_out == 8'hFF && target_out == ADC_TGT_PERIPH
        && width_out == ($past(req_in.addr[8]) ? ADC_W16 : ADC_W8); endproperty
    a_per: assert property (p_per) else $error("peripheral decode wrong");
    property p_a5x; v && ar == 3'h5 && a27 |=> area_select_n_out == 8'hDF && width_out == ADC_W16; endproperty
    a_a5x: assert property (p_a5x) else $error("area 5 external wrong");
    property p_ram; v && ar == 3'h7 && a27 |=> area_select_n_out == 8'hFF && target_out == ADC_TGT_RAM
        && width_out == ADC_W32 && ext_addr_out[9:0] == $past(req_in.addr[9:0]); endproperty
    a_ram: assert property (p_ram) else $error("ram decode wrong");
    property p_a7x; v && ar == 3'h7 && !a27 |=> area_select_n_out == 8'h7F && width_out == ADC_W8
        && !ext_a23_a22_drive_out; endproperty
    a_a7x: assert property (p_a7x) else $error("area 7 external wrong");
    property p_drv; ext_a23_a22_drive_out |-> row_col_mux_out && target_out == ADC_TGT_DRAM
        && area_select_n_out == 8'hFF; endproperty
    a_drv: assert property (p_drv) else $error("upper bits driven outside dram");
    property p_lw; long_wait_out != 3'h0 |-> long_wait_out <= 3'h4 && target_out == ADC_TGT_EXT
        && area_select_n_out inside {8'hFE, 8'hFB, 8'hBF}; endproperty
    a_lw: assert property (p_lw) else $error("long wait outside areas 0 2 6");
    c_ram: cover property (v && ar == 3'h7 && a27);
    c_dram: cover property (row_col_mux_out);
    c_per: cover property (v && ar == 3'h5 && !a27);
endmodule
bind adc_area_decode adc_area_decode_chk chk_u (.mclk_in, .nrst_in, .req_in, .boot_mode_pins_in, .hsel_in,
    .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
    .hresp_out, .area_select_n_out, .target_out, .width_out, .ext_addr_out, .ext_a23_a22_drive_out,
    .row_col_mux_out, .long_wait_out);

// file: testbench/adc_ext_mem.sv
`timescale 1ns/100ps
// far-side memories: records which selects were seen low
module adc_ext_mem (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] sel_n_in,
    output logic [7:0] hit_out
);
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            hit_out <= 8'h00;
        end else begin
            hit_out <= hit_out | ~sel_n_in;
        end
    end
endmodule

// file: testbench/tb_area_decode_chip_select.sv
`timescale 1ns/100ps
module tb_area_decode_chip_select import adc_pkg::*;;
    logic mclk = 1'b0, nrst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp, drv, rcm;
    adc_req_t req = '0;
    logic [2:0] mode = 3'h0, lw;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0] sel_n, hit;
    logic [23:0] xa;
    adc_target_t tgt;
    adc_width_t wid;
    int n_errors = 0, n_checks = 0;
    always #5 mclk = ~mclk;
    adc_area_decode dut_u (.mclk_in(mclk), .nrst_in(nrst_n), .req_in(req), .boot_mode_pins_in(mode),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .area_select_n_out(sel_n), .target_out(tgt), .width_out(wid),
        .ext_addr_out(xa), .ext_a23_a22_drive_out(drv), .row_col_mux_out(rcm), .long_wait_out(lw));
    adc_ext_mem mem_u (.mclk_in(mclk), .nrst_in(nrst_n), .sel_n_in(sel_n), .hit_out(hit));
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= wr;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        q = hrdata;
    endtask
    task dec(input logic [31:0] a, input logic [7:0] s, input adc_target_t t, input adc_width_t w,
        input logic [2:0] l);
        @(posedge mclk);
        req <= '{1'b1, a};
        repeat (2) @(posedge mclk);
        chk("sel", sel_n, s);
        chk("target", tgt, t);
        chk("width", wid, w);
        chk("long_wait", lw, l);
    endtask
    task t_regs;
        chk("sel_rst", sel_n, 8'hFF);
        chk("resp", hresp, 1'b0);
        ahb(1'b0, 12'h008, 32'h0);
        chk("lwait_rst", q, 32'hF);
        ahb(1'b1, 12'h008, 32'h6);
        ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
        ahb(1'b0, 12'h010, 32'h0);
        chk("unmapped", q, 32'h0);
        ahb(1'b0, 12'h008, 32'h0);
        chk("lwait", q, 32'h6);
    endtask
    task t_areas;
        dec(32'h0800_0000, 8'hFE, ADC_TGT_EXT, ADC_W8, 3'h3);
        dec(32'h0900_0000, 8'hFD, ADC_TGT_EXT, ADC_W16, 3'h0);
        dec(32'hF212_3456, 8'hFB, ADC_TGT_EXT, ADC_W8, 3'h3);
        chk("shadow", xa[21:0], 22'h12_3456);
        dec(32'h0AD2_3456, 8'hFB, ADC_TGT_EXT, ADC_W16, 3'h3);
        chk("shadow", xa[21:0], 22'h12_3456);
        dec(32'h0B00_0000, 8'hF7, ADC_TGT_EXT, ADC_W16, 3'h0);
        dec(32'h0400_0000, 8'hEF, ADC_TGT_EXT, ADC_W8, 3'h0);
        dec(32'h05FF_FF10, 8'hFF, ADC_TGT_PERIPH, ADC_W16, 3'h0);
        chk("periph_addr", xa[8:0], 9'h110);
        dec(32'h0D00_0000, 8'hDF, ADC_TGT_EXT, ADC_W16, 3'h0);
        dec(32'h0600_0000, 8'hBF, ADC_TGT_EXT, ADC_W8, 3'h2);
        dec(32'h0E00_0000, 8'hBF, ADC_TGT_EXT, ADC_W16, 3'h2);
        dec(32'h0700_0000, 8'h7F, ADC_TGT_EXT, ADC_W8, 3'h0);
        dec(32'h0FFF_FFFF, 8'hFF, ADC_TGT_RAM, ADC_W32, 3'h0);
        @(posedge mclk);
        req <= '0;
        repeat (2) @(posedge mclk);
        chk("sel_idle", sel_n, 8'hFF);
        chk("hits", hit, 8'hFF);
    endtask
    task t_enables;
        ahb(1'b1, 12'h000, 32'h3);
        dec(32'h0100_0000, 8'hFF, ADC_TGT_DRAM, ADC_W8, 3'h0);
        dec(32'h0600_4000, 8'hBF, ADC_TGT_MUXIO, ADC_W16, 3'h0);
        dec(32'h0E00_0000, 8'hBF, ADC_TGT_EXT, ADC_W16, 3'h2);
        ahb(1'b1, 12'h004, 32'h1);
        dec(32'h09C0_0001, 8'hFF, ADC_TGT_DRAM, ADC_W16, 3'h0);
        chk("mux_addr", {drv, rcm, xa}, {2'h3, 24'hC0_0001});
        dec(32'h0200_0000, 8'hFB, ADC_TGT_EXT, ADC_W8, 3'h3);
        chk("drive", drv, 1'b0);
        ahb(1'b0, 12'h00C, 32'h0);
        chk("status", q, 32'hFB40_0600);
    endtask
    task t_modes;
        mode <= 3'h2;
        repeat (4) @(posedge mclk);
        dec(32'h08FF_C123, 8'hFF, ADC_TGT_ROM, ADC_W32, 3'h0);
        chk("rom_addr", xa[13:0], 14'h0123);
        mode <= 3'h1;
        repeat (4) @(posedge mclk);
        dec(32'h0000_0000, 8'hFE, ADC_TGT_EXT, ADC_W16, 3'h3);
    endtask
    task close_out;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        nrst_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_areas;
        t_enables;
        t_modes;
        close_out;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        close_out;
    end
endmodule
